// File: design/ssc_top.sv
// Serial programming and register control of a triple-PLL synthesizer
`timescale 1ns/1ps

// How it works
// - A word is 22 bits: 18 data bits then a 4-bit register address.
// - While enable is low, each serial clock rise shifts one data bit in.
// - Enable rising commits the data field to the addressed register.
// - While enable is high, serial clock and data are ignored.
// - Only one RF PLL is active: the one whose divider was written last.
// - RF output follows the RF PLL whose R or N divider was last written.
// - Self-tuning starts on PLL power-up, or on frequency change while powered.
// - RF PLLs divide by two ahead of N; the IF PLL does not.
// - IF output post-divider selects one, two, four or eight.
// - Main config bit D6 halves the reference clock input.
// - Power-down pin low powers everything down, whatever the register says.
// - Power-down pin high leaves power to the register bits.
// - Power register holds separate active-high IF and RF power bits.
// - Reference amplifier is on when either section power bit is high.
// - Auto power-up bit acts as if both section power bits were set.
// - Serial programming works in every power-down state.
// - Low-bias bit reduces IF output amplifier bias current.
module ssc_top
    import ssc_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  ce_in,
    input  wire logic                  serial_clock_in,
    input  wire logic                  serial_data_in,
    input  wire logic                  serial_enable_n_in,
    input  wire logic                  powerdown_pin_n_in,
    output logic                       ref_prediv_two_out,
    output logic                       if_out_low_bias_out,
    output logic [3:0]                 if_post_div_out,
    output logic                       if_section_power_out,
    output logic                       rf_section_power_out,
    output logic                       ref_amp_power_out,
    output logic                       rf_low_band_sel_out,
    output logic [`SSC_DATA_W:0]       rf_feedback_div_out,
    output logic [`SSC_DATA_W-1:0]     rf_ref_div_out,
    output logic [`SSC_DATA_W-1:0]     if_feedback_div_out,
    output logic [`SSC_DATA_W-1:0]     if_ref_div_out,
    output logic [2:0]                 tune_start_out
);

    function automatic logic [3:0] ssc_ratio(input logic [1:0] code);
        ssc_ratio = `SSC_RST_RATIO << code;
    endfunction

    function automatic logic ssc_hit(input ssc_word_t w, input logic [`SSC_ADDR_W-1:0] a);
        ssc_hit = (w.addr == a);
    endfunction

    // Pin synchronisers: bit 0 clock, 1 data, 2 enable, 3 power-down
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] prev_q;
    logic [3:0] pins;
    logic       sclk_rise;
    logic       en_rise;
    logic       en_s;
    logic       pdn_s;

    assign pins      = {powerdown_pin_n_in, serial_enable_n_in, serial_data_in, serial_clock_in};
    assign en_s      = sync2_q[2];
    assign pdn_s     = sync2_q[3];
    assign sclk_rise = sync2_q[0] & ~prev_q[0];
    assign en_rise   = sync2_q[2] & ~prev_q[2];

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_q <= `SSC_RST_SYNC;
            sync2_q <= `SSC_RST_SYNC;
            prev_q  <= `SSC_RST_SYNC;
        end else if (ce_in) begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Serial shifter and commit sequencing
    ssc_ser_t  state_q;
    ssc_ser_t  state_d;
    ssc_word_t shreg_q;
    ssc_word_t shreg_d;
    logic      commit;

    assign commit = (state_q == SSC_COMMIT);

    always_comb begin
        state_d = state_q;
        shreg_d = shreg_q;
        if (!en_s && sclk_rise) begin
            shreg_d = {shreg_q[`SSC_WORD_W-2:0], sync2_q[1]};
        end
        unique case (state_q)
            SSC_IDLE: begin
                if (!en_s) begin
                    state_d = SSC_SHIFT;
                end
            end
            SSC_SHIFT: begin
                if (en_rise) begin
                    state_d = SSC_COMMIT;
                end
            end
            SSC_COMMIT: begin
                state_d = en_s ? SSC_IDLE : SSC_SHIFT;
            end
            default: begin
                state_d = SSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= SSC_IDLE;
            shreg_q <= `SSC_RST_WORD;
        end else if (ce_in) begin
            state_q <= state_d;
            shreg_q <= shreg_d;
        end
    end

    // Internal registers, in any power state: settings written only on commit, chg_q on every cycle
    logic [`SSC_DATA_W-1:0] main_q, main_d, pwr_q, pwr_d;
    logic [`SSC_DATA_W-1:0] rf1n_q, rf1n_d, rf2n_q, rf2n_d, ifn_q, ifn_d;
    logic [`SSC_DATA_W-1:0] rf1r_q, rf1r_d, rf2r_q, rf2r_d, ifr_q, ifr_d;
    logic                   sel_q, sel_d;
    logic [2:0]             chg_q, chg_d;

    always_comb begin
        main_d = main_q;
        pwr_d  = pwr_q;
        rf1n_d = rf1n_q;
        rf2n_d = rf2n_q;
        ifn_d  = ifn_q;
        rf1r_d = rf1r_q;
        rf2r_d = rf2r_q;
        ifr_d  = ifr_q;
        sel_d  = sel_q;
        chg_d  = `SSC_RST_TUNE;
        if (commit) begin
            if (ssc_hit(shreg_q, `SSC_A_MAIN)) begin
                main_d = shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_PWR)) begin
                pwr_d = shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_HI_N) || ssc_hit(shreg_q, `SSC_A_HI_R)) begin
                sel_d = 1'b0;
                chg_d[`SSC_T_HI] = sel_q ||
                    (ssc_hit(shreg_q, `SSC_A_HI_N) ? rf1n_q : rf1r_q) != shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_LO_N) || ssc_hit(shreg_q, `SSC_A_LO_R)) begin
                sel_d = 1'b1;
                chg_d[`SSC_T_LO] = !sel_q ||
                    (ssc_hit(shreg_q, `SSC_A_LO_N) ? rf2n_q : rf2r_q) != shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_IF_N) || ssc_hit(shreg_q, `SSC_A_IF_R)) begin
                chg_d[`SSC_T_IF] =
                    (ssc_hit(shreg_q, `SSC_A_IF_N) ? ifn_q : ifr_q) != shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_HI_N)) begin
                rf1n_d = shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_LO_N)) begin
                rf2n_d = shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_IF_N)) begin
                ifn_d = shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_HI_R)) begin
                rf1r_d = shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_LO_R)) begin
                rf2r_d = shreg_q.data;
            end
            if (ssc_hit(shreg_q, `SSC_A_IF_R)) begin
                ifr_d = shreg_q.data;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            main_q <= `SSC_RST_DATA;
            pwr_q  <= `SSC_RST_DATA;
            rf1n_q <= `SSC_RST_DATA;
            rf2n_q <= `SSC_RST_DATA;
            ifn_q  <= `SSC_RST_DATA;
            rf1r_q <= `SSC_RST_DATA;
            rf2r_q <= `SSC_RST_DATA;
            ifr_q  <= `SSC_RST_DATA;
            sel_q  <= 1'b0;
            chg_q  <= `SSC_RST_TUNE;
        end else if (ce_in) begin
            main_q <= main_d;
            pwr_q  <= pwr_d;
            rf1n_q <= rf1n_d;
            rf2n_q <= rf2n_d;
            ifn_q  <= ifn_d;
            rf1r_q <= rf1r_d;
            rf2r_q <= rf2r_d;
            ifr_q  <= ifr_d;
            sel_q  <= sel_d;
            chg_q  <= chg_d;
        end
    end

    // Registered outputs: power, options, dividers and tuning starts
    ssc_pwr_t               pwr_out_d;
    logic                   auto_pu;
    logic [`SSC_DATA_W-1:0] act_n;
    logic [2:0]             tune_d;

    assign auto_pu = main_q[`SSC_B_AUTOPU];
    assign act_n   = sel_q ? rf2n_q : rf1n_q;

    always_comb begin
        pwr_out_d.if_on  = pdn_s & (pwr_q[`SSC_B_IFPWR] | auto_pu);
        pwr_out_d.rf_on  = pdn_s & (pwr_q[`SSC_B_RFPWR] | auto_pu);
        pwr_out_d.ref_on = pwr_out_d.if_on | pwr_out_d.rf_on;
        tune_d[`SSC_T_IF] = pwr_out_d.if_on & (~if_section_power_out | chg_q[`SSC_T_IF]);
        tune_d[`SSC_T_HI] = pwr_out_d.rf_on & ~sel_q &
                            (~rf_section_power_out | chg_q[`SSC_T_HI]);
        tune_d[`SSC_T_LO] = pwr_out_d.rf_on & sel_q &
                            (~rf_section_power_out | chg_q[`SSC_T_LO]);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ref_prediv_two_out   <= 1'b0;
            if_out_low_bias_out  <= 1'b0;
            if_post_div_out      <= `SSC_RST_RATIO;
            if_section_power_out <= 1'b0;
            rf_section_power_out <= 1'b0;
            ref_amp_power_out    <= 1'b0;
            rf_low_band_sel_out  <= 1'b0;
            rf_feedback_div_out  <= {`SSC_RST_DATA, 1'b0};
            rf_ref_div_out       <= `SSC_RST_DATA;
            if_feedback_div_out  <= `SSC_RST_DATA;
            if_ref_div_out       <= `SSC_RST_DATA;
            tune_start_out       <= `SSC_RST_TUNE;
        end else if (ce_in) begin
            ref_prediv_two_out   <= main_q[`SSC_B_REFDIV];
            if_out_low_bias_out  <= main_q[`SSC_B_LOWBIAS];
            if_post_div_out      <= ssc_ratio(main_q[`SSC_B_IFDIV_HI:`SSC_B_IFDIV_LO]);
            if_section_power_out <= pwr_out_d.if_on;
            rf_section_power_out <= pwr_out_d.rf_on;
            ref_amp_power_out    <= pwr_out_d.ref_on;
            rf_low_band_sel_out  <= sel_q;
            rf_feedback_div_out  <= {act_n, 1'b0};
            rf_ref_div_out       <= sel_q ? rf2r_q : rf1r_q;
            if_feedback_div_out  <= ifn_q;
            if_ref_div_out       <= ifr_q;
            tune_start_out       <= tune_d;
        end
    end

    // Checks
    shift_in_bit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && !en_s && sclk_rise |=>
            shreg_q == {$past(shreg_q[`SSC_WORD_W-2:0]), $past(sync2_q[1])})
        else $error("serial bit not shifted in");
    shift_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        en_s |=> $stable(shreg_q))
        else $error("shift register moved while enable high");
    commit_main_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && commit && shreg_q.addr == `SSC_A_MAIN |=> main_q == $past(shreg_q.data))
        else $error("main config not committed");
    commit_seq_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && state_q == SSC_SHIFT && en_rise |=> commit)
        else $error("enable rise did not commit");
    band_select_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && commit && shreg_q.addr == `SSC_A_LO_N) ##1 ce_in |=> rf_low_band_sel_out)
        else $error("low band not selected after its divider write");
    prescale_two_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in |=> rf_feedback_div_out == {$past(act_n), 1'b0})
        else $error("RF feedback divide not doubled");
    post_div_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $onehot(if_post_div_out) && if_post_div_out <= 4'h8)
        else $error("illegal IF post-divide ratio");
    options_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in |=> ref_prediv_two_out == $past(main_q[`SSC_B_REFDIV]) &&
                  if_out_low_bias_out == $past(main_q[`SSC_B_LOWBIAS]))
        else $error("main config option not applied");
    pin_down_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && !pdn_s |=> !if_section_power_out && !rf_section_power_out && !ref_amp_power_out)
        else $error("power-down pin ignored");
    reg_power_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && pdn_s && !auto_pu |=> if_section_power_out == $past(pwr_q[`SSC_B_IFPWR]) &&
                                       rf_section_power_out == $past(pwr_q[`SSC_B_RFPWR]))
        else $error("section power not from register");
    ref_amp_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ref_amp_power_out == (if_section_power_out | rf_section_power_out))
        else $error("reference amplifier power wrong");
    auto_power_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && pdn_s && auto_pu |=> if_section_power_out && rf_section_power_out)
        else $error("auto power-up ignored");
    tune_powerup_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(if_section_power_out) |-> tune_start_out[`SSC_T_IF])
        else $error("no IF tuning on power-up");
    cover_pwr_write_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        commit && shreg_q.addr == `SSC_A_PWR);
    cover_band_swap_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(rf_low_band_sel_out));
    cover_tune_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        rf_section_power_out && tune_start_out[`SSC_T_HI]);

endmodule

// File: inc/ssc_defines.svh
// Widths, register addresses, field positions and reset values of the serial config block
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

`define SSC_WORD_W      22
`define SSC_DATA_W      18
`define SSC_ADDR_W      4

`define SSC_A_MAIN      4'h0
`define SSC_A_PWR       4'h2
`define SSC_A_HI_N      4'h3
`define SSC_A_LO_N      4'h4
`define SSC_A_IF_N      4'h5
`define SSC_A_HI_R      4'h6
`define SSC_A_LO_R      4'h7
`define SSC_A_IF_R      4'h8

`define SSC_B_IFDIV_LO  2
`define SSC_B_IFDIV_HI  3
`define SSC_B_AUTOPU    5
`define SSC_B_REFDIV    6
`define SSC_B_LOWBIAS   11
`define SSC_B_RFPWR     0
`define SSC_B_IFPWR     1

`define SSC_T_IF        0
`define SSC_T_HI        1
`define SSC_T_LO        2

`define SSC_RST_DATA    18'h00000
`define SSC_RST_WORD    22'h000000
`define SSC_RST_SYNC    4'h4
`define SSC_RST_TUNE    3'h0
`define SSC_RST_RATIO   4'h1

`endif

// File: inc/ssc_pkg.sv
// Types shared by the serial config block
`include "ssc_defines.svh"
package ssc_pkg;
    typedef struct packed {
        logic [`SSC_DATA_W-1:0] data;
        logic [`SSC_ADDR_W-1:0] addr;
    } ssc_word_t;

    typedef enum logic [1:0] {
        SSC_IDLE   = 2'h0,
        SSC_SHIFT  = 2'h1,
        SSC_COMMIT = 2'h3
    } ssc_ser_t;

    typedef struct packed {
        logic if_on;
        logic rf_on;
        logic ref_on;
    } ssc_pwr_t;
endpackage

// File: verif/ssc_host_model.sv
// Host controller model that drives the three-wire serial programming link
`timescale 1ns/1ps
module ssc_host_model (
    input  wire logic clk_in,
    output logic      serial_clock_out,
    output logic      serial_data_out,
    output logic      serial_enable_n_out
);
    initial begin
        serial_clock_out    = 1'b0;
        serial_data_out     = 1'b0;
        serial_enable_n_out = 1'b1;
    end

    // Shifts the low n bits of w, MSB first; half is the clock half period in clk cycles
    task automatic send_bits(input logic [21:0] w, input int n, input int half);
        @(posedge clk_in);
        serial_enable_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_out <= w[i];
            repeat (half) @(posedge clk_in);
            serial_clock_out <= 1'b1;
            repeat (half) @(posedge clk_in);
            serial_clock_out <= 1'b0;
        end
        repeat (half) @(posedge clk_in);
        serial_enable_n_out <= 1'b1;
        // A released data line must not keep showing the last bit
        serial_data_out <= ~serial_data_out;
        repeat (4) @(posedge clk_in);
    endtask

    task automatic send_word(input logic [3:0] addr, input logic [17:0] data, input int half);
        send_bits({data, addr}, 22, half);
    endtask

    // Ones on the data line, clocked while the link is disabled
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            serial_data_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            serial_clock_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            serial_clock_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// File: verif/test_synth_serial_config.sv
// Self-checking testbench of the serial config block
`timescale 1ns/1ps
`include "ssc_defines.svh"
module test_synth_serial_config;
    logic        clk_in;
    logic        resetn_in;
    logic        powerdown_pin_n_in;
    logic        sclk;
    logic        ser_data;
    logic        ser_en_n;
    logic        prediv;
    logic        low_bias;
    logic [3:0]  post_div;
    logic        if_pwr;
    logic        rf_pwr;
    logic        ref_pwr;
    logic        low_band;
    logic [18:0] rf_n;
    logic [17:0] rf_r;
    logic [17:0] if_n;
    logic [17:0] if_r;
    logic [2:0]  tune;
    logic [2:0]  tune_seen;
    logic        tune_clr;
    int          fail_count;
    int          comparisons;

    ssc_host_model ssc_host_model_i (
        .clk_in(clk_in), .serial_clock_out(sclk), .serial_data_out(ser_data),
        .serial_enable_n_out(ser_en_n)
    );
    ssc_top ssc_top_i (
        .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .serial_clock_in(sclk),
        .serial_data_in(ser_data), .serial_enable_n_in(ser_en_n),
        .powerdown_pin_n_in(powerdown_pin_n_in), .ref_prediv_two_out(prediv),
        .if_out_low_bias_out(low_bias), .if_post_div_out(post_div),
        .if_section_power_out(if_pwr), .rf_section_power_out(rf_pwr),
        .ref_amp_power_out(ref_pwr), .rf_low_band_sel_out(low_band),
        .rf_feedback_div_out(rf_n), .rf_ref_div_out(rf_r), .if_feedback_div_out(if_n),
        .if_ref_div_out(if_r), .tune_start_out(tune)
    );

    initial clk_in = 1'b0;
    always #10 clk_in = ~clk_in;

    // Collects one-cycle tune pulses since the last clear
    always @(posedge clk_in) begin
        tune_seen <= tune_clr ? 3'h0 : (tune_seen | tune);
    end

    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Clears the tune record, writes one word, waits past the output update
    task automatic wr(input logic [3:0] addr, input logic [17:0] data, input int half);
        @(posedge clk_in);
        tune_clr <= 1'b1;
        @(posedge clk_in);
        tune_clr <= 1'b0;
        ssc_host_model_i.send_word(addr, data, half);
        repeat (8) @(posedge clk_in);
        #1;
    endtask

    task automatic set_pin(input logic level);
        @(posedge clk_in);
        powerdown_pin_n_in <= level;
        repeat (6) @(posedge clk_in);
        #1;
    endtask

    task automatic check_power(input logic [2:0] exp);
        check({if_pwr, rf_pwr, ref_pwr}, exp);
    endtask

    task automatic t_reset();
        check({prediv, low_bias, post_div, low_band}, 7'h02);
        check_power(3'h0);
        check(rf_n, 19'h0);
    endtask

    task automatic t_main();
        logic [17:0] d;
        for (int c = 0; c < 4; c++) begin
            d = 18'(c << 2) | 18'((c & 1) << 6) | 18'((c >> 1) << 11);
            wr(`SSC_A_MAIN, d, 4);
            check(post_div, 19'(1 << c));
            check(prediv, 19'(c & 1));
            check(low_bias, 19'(c >> 1));
        end
        wr(4'h1, 18'h3fffc, 4);
        check({prediv, low_bias, post_div}, 6'h38);
        wr(`SSC_A_MAIN, 18'h00000, 4);
    endtask

    task automatic t_power();
        wr(`SSC_A_PWR, 18'h00001, 4);
        check_power(3'h3);
        check(tune_seen, 3'h2);
        wr(`SSC_A_PWR, 18'h00002, 4);
        check_power(3'h5);
        check(tune_seen, 3'h1);
        wr(`SSC_A_PWR, 18'h00000, 4);
        check_power(3'h0);
        wr(`SSC_A_MAIN, 18'h00020, 4);
        check_power(3'h7);
        set_pin(1'b0);
        check_power(3'h0);
        wr(`SSC_A_MAIN, 18'h00000, 4);
        wr(`SSC_A_PWR, 18'h00002, 4);
        check_power(3'h0);
        set_pin(1'b1);
        check_power(3'h5);
        wr(`SSC_A_PWR, 18'h00003, 4);
    endtask

    task automatic t_select();
        wr(`SSC_A_LO_N, 18'h00123, 4);
        check(low_band, 19'h1);
        check(rf_n, 19'h00246);
        check(tune_seen, 3'h4);
        wr(`SSC_A_LO_R, 18'h00abc, 4);
        check({low_band, rf_r}, 19'h40abc);
        check(tune_seen, 3'h4);
        wr(`SSC_A_HI_R, 18'h00045, 4);
        check({low_band, rf_r}, 19'h00045);
        check(rf_n, 19'h0);
        wr(`SSC_A_HI_N, 18'h2aaaa, 4);
        check(rf_n, 19'h55554);
        wr(`SSC_A_IF_N, 18'h00777, 10);
        check(if_n, 19'h00777);
        check(tune_seen, 3'h1);
        wr(`SSC_A_IF_N, 18'h00777, 4);
        check(tune_seen, 3'h0);
        wr(`SSC_A_IF_R, 18'h12345, 4);
        check(if_r, 19'h12345);
    endtask

    // The short frame takes its top bit from the last bit of the previous word
    task automatic t_ignore();
        wr(`SSC_A_LO_N, 18'h00001, 4);
        ssc_host_model_i.idle_clocks(3);
        ssc_host_model_i.send_bits({18'h00055, `SSC_A_IF_N}, 21, 4);
        repeat (8) @(posedge clk_in);
        #1;
        check(if_n, 19'h00055);
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #1ms;
        fail_count++;
        $display("watchdog expired at %0t ns", $time);
        close_out();
    end

    initial begin
        resetn_in          = 1'b0;
        powerdown_pin_n_in = 1'b1;
        tune_clr           = 1'b1;
        fail_count         = 0;
        comparisons        = 0;
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        tune_clr  <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        t_reset();
        t_main();
        t_power();
        t_select();
        t_ignore();
        close_out();
    end
endmodule
